//--- shared/dsfc_pkg.sv
// shared constants and types for the switchover and fast-lock controller
`default_nettype none
package dsfc_pkg;
  localparam int NREF = 4;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PRIO   = 8'h04;
  localparam logic [7:0] ADDR_PSL    = 8'h08;
  localparam logic [7:0] ADDR_MAXF   = 8'h0C;
  localparam logic [7:0] ADDR_FLCFG  = 8'h10;
  localparam logic [7:0] ADDR_FLLIM  = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PHZERO = 8'h1C;
  localparam logic [31:0] RST_CTRL  = 32'h0000_00F0;
  localparam logic [31:0] RST_PRIO  = 32'h0000_3210;
  localparam logic [31:0] RST_PSL   = 32'h0000_0374;
  localparam logic [31:0] RST_MAXF  = 32'h0000_FFFF;
  localparam logic [31:0] RST_FLCFG = 32'h0000_0000;
  localparam logic [31:0] RST_FLLIM = 32'hFFFF_FFFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pre-acquisition is counted in milliseconds of the 100 MHz clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_IN_NS      = 1000000;
  localparam int MS_CYCLES     = MS_IN_NS / CLK_PERIOD_NS;
  // slope cap code n means n+1 ns/s, so 16 bits span 1 ns/s .. 65536 ns/s
  localparam int PSL_W = 16;
  localparam int FREQ_W = 24;
  localparam int PHASE_W = 16;
  typedef enum logic [2:0] {
    ST_FREE    = 3'b000,
    ST_ACQ     = 3'b001,
    ST_LOCK    = 3'b010,
    ST_HOLD    = 3'b011,
    ST_HITHOLD = 3'b100,
    ST_REC     = 3'b101
  } dsfc_state_t;
  typedef enum logic [2:0] {
    FL_NONE  = 3'b000,
    FL_FSNAP = 3'b001,
    FL_PSNAP = 3'b010,
    FL_OPEN  = 3'b011,
    FL_PRE   = 3'b100,
    FL_WIDE  = 3'b101
  } dsfc_fl_t;
  typedef struct packed {
    logic [23:0] rsvd;
    logic [3:0]  refEn;
    logic        pslEn;
    logic        hsType;
    logic        hsEn;
    logic        revert;
  } dsfc_ctrl_t;
  typedef struct packed {
    logic [15:0] preMs;
    logic [1:0]  rsvd;
    logic        fslEn;
    logic        preEn;
    logic [3:0]  recSel;
    logic [3:0]  acqSel;
    logic [3:0]  optEn;
  } dsfc_flcfg_t;
  typedef struct packed {
    logic        fodWrite;
    logic        phaseSnap;
    logic        openLoop;
    logic        bwMax;
    logic        wideAcq;
  } dsfc_act_t;
endpackage : dsfc_pkg
`default_nettype wire

//--- hw/dsfc_ctrl.sv
// reference switchover and fast-lock controller for one DPLL
//
// How it works
// - revertive selectable, resets non-revertive
// - pick highest priority qualified reference, then lock
// - non-revertive moves only when present reference invalid
// - revertive switches up, except within same group
// - hitless switching enabled per configuration bit
// - locked reference change triggers hitless switch
// - leaving holdover to lock triggers hitless switch
// - hitless passes temporary holdover without alarm
// - measured offset becomes phase detector zero
// - measure offset before closing loop after holdover
// - two hitless variants, selected by configuration
// - phase slope cap enabled and programmed separately
// - slope cap 1 ns/s steps to 65.536 us/s
// - disabled cap means bandwidth-limited; telecom values reachable
// - frequency clamped to programmable maximum offset
// - each fast-lock option enabled, chosen per state
// - fixed precedence; phase snap excludes open loop
// - frequency snap writes offset to divider, optional cap
// - phase snap sets phase; open loop isolates filter
// - wide acquisition relaxes limits until lock
// - acquire-only pre-acquisition opens bandwidth for ms
// - qualified means enabled and monitor-valid
// - all references invalid enters holdover
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dsfc_ctrl
  import dsfc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic [NREF-1:0]           refValid,
  input  wire logic                      lockDetect,
  input  wire logic                      phaseMeasDone,
  input  wire logic signed [PHASE_W-1:0] measPhase,
  input  wire logic                      freqMeasDone,
  input  wire logic signed [FREQ_W-1:0]  measFreq,
  input  wire logic signed [FREQ_W-1:0]  loopFreq,
  output logic [1:0]                     selRef,
  output logic                           refActive,
  output logic                           holdover,
  output logic                           holdAlarm,
  output logic                           hsType,
  output logic signed [PHASE_W-1:0]      phaseZero,
  output logic signed [PHASE_W-1:0]      snapPhase,
  output logic signed [FREQ_W-1:0]       fodWord,
  output logic signed [FREQ_W-1:0]       freqCmd,
  output logic                           pslOn,
  output logic [PSL_W-1:0]               pslCode,
  output dsfc_act_t                      act
);

  function automatic logic [31:0] strobe(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : strobe

  function automatic logic signed [FREQ_W-1:0] clampf(
      input logic signed [FREQ_W-1:0] v, input logic [FREQ_W-1:0] lim);
    logic signed [FREQ_W:0] sv;
    logic signed [FREQ_W:0] sl;
    sv = {v[FREQ_W-1], v};
    sl = {1'b0, lim};
    if (sv > sl) begin
      return lim;
    end else if (sv < -sl) begin
      return FREQ_W'(-sl);
    end
    return v;
  endfunction : clampf

  // register file
  dsfc_ctrl_t  ctrl;
  dsfc_flcfg_t flcfg;
  logic [31:0] prio;
  logic [31:0] pslReg;
  logic [31:0] maxfReg;
  logic [31:0] fllim;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;

  dsfc_state_t state;
  dsfc_state_t next_state;
  dsfc_fl_t    flMode;
  dsfc_fl_t    next_flMode;
  dsfc_fl_t    startMode;
  logic [1:0]  next_selRef;
  logic [15:0] preLeft;
  logic [31:0] msCnt;

  // bus slave: address and data caught in either order
  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;
  wire doWrite = awHeld && wHeld && !bvalid;
  wire doRead  = arvalid && arready;
  wire wrCtrl  = doWrite && awAddrQ == ADDR_CTRL;
  wire wrPrio  = doWrite && awAddrQ == ADDR_PRIO;
  wire wrPsl   = doWrite && awAddrQ == ADDR_PSL;
  wire wrMaxf  = doWrite && awAddrQ == ADDR_MAXF;
  wire wrFlcfg = doWrite && awAddrQ == ADDR_FLCFG;
  wire wrFllim = doWrite && awAddrQ == ADDR_FLLIM;
  wire wrHit   = wrCtrl || wrPrio || wrPsl || wrMaxf || wrFlcfg || wrFllim;
  wire rdHit   = araddr[7:5] == 3'h0 && araddr[1:0] == 2'h0;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ  <= 32'h0000_0000;
      wStrbQ  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld  <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld  <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl    <= RST_CTRL;
      prio    <= RST_PRIO;
      pslReg  <= RST_PSL;
      maxfReg <= RST_MAXF;
      flcfg   <= RST_FLCFG;
      fllim   <= RST_FLLIM;
    end else begin
      if (wrCtrl) ctrl <= strobe(ctrl, wDataQ, wStrbQ);
      if (wrPrio) prio <= strobe(prio, wDataQ, wStrbQ);
      if (wrPsl) pslReg <= strobe(pslReg, wDataQ, wStrbQ);
      if (wrMaxf) maxfReg <= strobe(maxfReg, wDataQ, wStrbQ);
      if (wrFlcfg) flcfg <= strobe(flcfg, wDataQ, wStrbQ);
      if (wrFllim) fllim <= strobe(fllim, wDataQ, wStrbQ);
    end
  end

  wire [31:0] statusWord = {17'h00000, msCnt == 32'h0, act, 1'b0, flMode,
                            state, selRef};
  wire [31:0] rdMux =
      araddr == ADDR_CTRL   ? ctrl :
      araddr == ADDR_PRIO   ? prio :
      araddr == ADDR_PSL    ? {16'h0000, pslReg[15:0]} :
      araddr == ADDR_MAXF   ? {8'h00, maxfReg[23:0]} :
      araddr == ADDR_FLCFG  ? flcfg :
      araddr == ADDR_FLLIM  ? fllim :
      araddr == ADDR_STATUS ? statusWord :
      {{(32-PHASE_W){phaseZero[PHASE_W-1]}}, phaseZero};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (doRead) begin
      rvalid <= 1'b1;
      rdata  <= rdHit ? rdMux : 32'h0000_0000;
      rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // reference choice: lower priority number wins, ties go to lower index
  wire [NREF-1:0] qual = ctrl.refEn & refValid;
  logic       bestValid;
  logic [1:0] bestIdx;
  logic [3:0] bestPrio;
  always_comb begin
    bestValid = 1'b0;
    bestIdx   = 2'h0;
    bestPrio  = 4'hF;
    for (int i = 0; i < NREF; i++) begin
      if (qual[i] && (!bestValid || prio[i*4 +: 4] < bestPrio)) begin
        bestValid = 1'b1;
        bestIdx   = 2'(i);
        bestPrio  = prio[i*4 +: 4];
      end
    end
  end

  wire [3:0] curPrio  = prio[selRef*4 +: 4];
  wire [3:0] curGrp   = prio[16 + selRef*4 +: 4];
  wire [3:0] bestGrp  = prio[16 + bestIdx*4 +: 4];
  wire       curQual  = qual[selRef];
  wire       sameGrp  = bestGrp != 4'h0 && bestGrp == curGrp;
  wire       revertWant = ctrl.revert && bestValid && bestIdx != selRef &&
                          bestPrio < curPrio && !sameGrp;
  wire       leaveLock = !curQual || revertWant;

  always_comb begin
    next_state  = state;
    next_selRef = selRef;
    case (state)
      ST_FREE: begin
        if (bestValid) begin
          next_selRef = bestIdx;
          next_state  = ST_ACQ;
        end
      end
      ST_ACQ, ST_REC, ST_HITHOLD: begin
        if (!curQual) begin
          next_selRef = bestIdx;
          next_state  = bestValid ? state : ST_HOLD;
        end else if (state == ST_HITHOLD) begin
          if (phaseMeasDone) next_state = ST_REC;
        end else if (lockDetect) begin
          next_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (leaveLock) begin
          next_selRef = bestIdx;
          next_state  = bestValid ? dsfc_state_t'(ctrl.hsEn ? ST_HITHOLD
                                                  : ST_REC)
                                  : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (bestValid) begin
          next_selRef = bestIdx;
          next_state  = ctrl.hsEn ? ST_HITHOLD : ST_REC;
        end
      end
      default: next_state = ST_FREE;
    endcase
  end

  // fast-lock chosen afresh on every entry or retarget
  wire enterLoop = (next_state == ST_ACQ || next_state == ST_REC) &&
                   (next_state != state || next_selRef != selRef);
  wire toAcq = next_state == ST_ACQ;
  wire [3:0] startSel = flcfg.optEn & (toAcq ? flcfg.acqSel : flcfg.recSel);
  // zero length skips the step instead of costing one cycle
  wire preFirst = toAcq && flcfg.preEn && flcfg.preMs != 16'h0;
  always_comb begin
    if (startSel[0]) startMode = FL_FSNAP;
    else if (startSel[1]) startMode = FL_PSNAP;
    else if (startSel[2]) startMode = FL_OPEN;
    else if (startSel[3]) startMode = preFirst ? FL_PRE : FL_WIDE;
    else startMode = FL_NONE;
  end

  wire msTick = msCnt == 32'(MS_CYC - 1);
  wire inLoop = state == ST_ACQ || state == ST_REC;
  // relaxed settings must not leak into holdover or lock
  wire nextInLoop = next_state == ST_ACQ || next_state == ST_REC;
  always_comb begin
    next_flMode = flMode;
    if (enterLoop) begin
      next_flMode = startMode;
    end else if (!nextInLoop || lockDetect) begin
      next_flMode = FL_NONE;
    end else begin
      case (flMode)
        FL_FSNAP: if (freqMeasDone) next_flMode = FL_NONE;
        FL_PSNAP: if (phaseMeasDone) next_flMode = FL_NONE;
        FL_PRE:   if (preLeft == 16'h0) next_flMode = FL_WIDE;
        FL_NONE, FL_OPEN, FL_WIDE: next_flMode = flMode;
        default:  next_flMode = FL_NONE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state  <= ST_FREE;
      selRef <= 2'h0;
      flMode <= FL_NONE;
    end else begin
      state  <= next_state;
      selRef <= next_selRef;
      flMode <= next_flMode;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || enterLoop || msTick) begin
      msCnt <= 32'h0;
    end else begin
      msCnt <= msCnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      preLeft <= 16'h0;
    end else if (enterLoop) begin
      preLeft <= flcfg.preMs;
    end else if (flMode == FL_PRE && msTick && preLeft != 16'h0) begin
      preLeft <= preLeft - 16'h1;
    end
  end

  // zero point: type selects how the loop uses it downstream
  wire capZero = state == ST_HITHOLD && curQual && phaseMeasDone;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phaseZero <= '0;
      hsType    <= 1'b0;
    end else if (capZero) begin
      phaseZero <= measPhase;
      hsType    <= ctrl.hsType;
    end
  end

  // snap step bounded by fllim[31:16] when fslEn is set, and never past the offset limit
  wire [FREQ_W-1:0] fslLim = {8'h00, fllim[31:16]};
  wire [FREQ_W-1:0] maxLim = maxfReg[FREQ_W-1:0];
  wire signed [FREQ_W-1:0] snapRaw = clampf(measFreq, maxLim);
  wire doFsnap = flMode == FL_FSNAP && inLoop && !lockDetect && freqMeasDone;
  wire doPsnap = flMode == FL_PSNAP && inLoop && !lockDetect && phaseMeasDone;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      act       <= '0;
      fodWord   <= '0;
      snapPhase <= '0;
    end else begin
      act.fodWrite  <= doFsnap;
      act.phaseSnap <= doPsnap;
      act.openLoop  <= next_flMode == FL_OPEN;
      act.bwMax     <= next_flMode == FL_PRE;
      act.wideAcq   <= next_flMode == FL_WIDE || next_flMode == FL_PRE;
      if (doFsnap) begin
        fodWord <= flcfg.fslEn ? clampf(snapRaw, fslLim) : snapRaw;
      end
      if (doPsnap) snapPhase <= measPhase;
    end
  end

  // relaxed cap replaces the normal one while acquiring wide
  wire relaxed = next_flMode == FL_PRE || next_flMode == FL_WIDE;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pslOn   <= 1'b0;
      pslCode <= '0;
      freqCmd <= '0;
    end else begin
      pslOn   <= relaxed || ctrl.pslEn;
      pslCode <= relaxed ? fllim[15:0] : pslReg[15:0];
      freqCmd <= clampf(loopFreq, maxLim);
    end
  end

  assign refActive = state == ST_ACQ || state == ST_LOCK || state == ST_REC;
  assign holdover  = state == ST_HOLD || state == ST_HITHOLD;
  assign holdAlarm = state == ST_HOLD;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_reset_nonrev;
    disable iff (1'b0) !resetn |=> !ctrl.revert;
  endproperty
  a_reset_nonrev: assert property (p_reset_nonrev)
    else $error("revertive mode set after reset");
  property p_pick_best;
    state == ST_FREE && bestValid |=>
      state == ST_ACQ && selRef == $past(bestIdx);
  endproperty
  a_pick_best: assert property (p_pick_best)
    else $error("free run did not take best reference");
  property p_stay_nonrev;
    state == ST_LOCK && !ctrl.revert && curQual |=>
      state == ST_LOCK && selRef == $past(selRef);
  endproperty
  a_stay_nonrev: assert property (p_stay_nonrev)
    else $error("non-revertive switch while reference valid");
  property p_revert;
    state == ST_LOCK && curQual && revertWant |=> selRef != $past(selRef);
  endproperty
  a_revert: assert property (p_revert)
    else $error("revertive switch missed");
  property p_hit_lock;
    state == ST_LOCK && ctrl.hsEn && leaveLock && bestValid |=>
      state == ST_HITHOLD;
  endproperty
  a_hit_lock: assert property (p_hit_lock)
    else $error("locked switch not hitless");
  property p_hit_hold;
    state == ST_HOLD && ctrl.hsEn && bestValid |=> state == ST_HITHOLD;
  endproperty
  a_hit_hold: assert property (p_hit_hold)
    else $error("holdover exit not hitless");
  property p_no_alarm;
    state == ST_HITHOLD |-> holdover && !holdAlarm;
  endproperty
  a_no_alarm: assert property (p_no_alarm)
    else $error("alarm raised in temporary holdover");
  sequence s_measured;
    state == ST_HITHOLD && curQual && phaseMeasDone;
  endsequence
  property p_zero_cap;
    s_measured |=> phaseZero == $past(measPhase) && state == ST_REC;
  endproperty
  a_zero_cap: assert property (p_zero_cap)
    else $error("zero point not captured before closing loop");
  property p_all_lost;
    state == ST_LOCK && !bestValid && !curQual |=> state == ST_HOLD;
  endproperty
  a_all_lost: assert property (p_all_lost)
    else $error("no holdover with all references lost");
  property p_fsnap_first;
    enterLoop && startSel[0] |=> flMode == FL_FSNAP ##1 flMode != FL_PSNAP;
  endproperty
  a_fsnap_first: assert property (p_fsnap_first)
    else $error("frequency snap lost precedence");
  property p_pre_acq;
    flMode == FL_PRE |-> state == ST_ACQ;
  endproperty
  a_pre_acq: assert property (p_pre_acq)
    else $error("pre-acquisition outside acquire state");
endmodule : dsfc_ctrl
`default_nettype wire

//--- verif/dsfc_ref_model.sv
// behavioural references, monitors and loop around the controller
`timescale 1ns/1ps
`default_nettype none
module dsfc_ref_model
  import dsfc_pkg::*;
#(
  parameter int LOCK_DLY = 6
) (
  input  wire logic                     clk,
  input  wire logic [NREF-1:0]          refUp,
  input  wire logic signed [FREQ_W-1:0] freqReq,
  input  wire logic                     refActive,
  input  wire logic                     holdover,
  input  wire logic                     holdAlarm,
  output logic [NREF-1:0]               refValid,
  output logic                          lockDetect,
  output logic                          phaseMeasDone,
  output logic signed [PHASE_W-1:0]     measPhase,
  output logic                          freqMeasDone,
  output logic signed [FREQ_W-1:0]      measFreq,
  output logic signed [FREQ_W-1:0]      loopFreq
);
  int         lockCnt = 0;
  int         hitCnt = 0;
  logic [7:0] tick = 8'h00;
  initial {refValid, lockDetect, phaseMeasDone, freqMeasDone} = '0;
  // measured values wander every cycle, so a stale capture shows up
  always @(posedge clk) begin
    tick <= tick + 8'h01;
    refValid <= refUp;
    loopFreq <= freqReq;
    // a change of references restarts the lock count
    lockCnt <= (refActive && refValid == refUp) ? lockCnt + 1 : 0;
    hitCnt <= (holdover && !holdAlarm) ? hitCnt + 1 : 0;
    lockDetect <= refActive && lockCnt >= LOCK_DLY;
    phaseMeasDone <= hitCnt == 2 || (refActive && lockCnt == 3);
    freqMeasDone <= refActive && lockCnt == 2;
    measPhase <= {tick, 8'h5A};
    // kept small so the default offset clamp never bites
    measFreq <= {12'h000, tick[3:0], 8'hA5};
  end
endmodule : dsfc_ref_model
`default_nettype wire

//--- verif/dsfc_ctrl_bench.sv
// self-checking bench for the switchover and fast-lock controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checksDone++; if ((s) !== (e)) begin \
  failures++; $display("FAIL %s exp %0h got %0h", n, e, s); end end
module dsfc_ctrl_bench
  import dsfc_pkg::*;
;
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lockDetect, phaseMeasDone;
  logic freqMeasDone, refActive, holdover, holdAlarm, hsType, pslOn;
  logic sawFod, sawWide, sawHit, sawAlarm, sawBw, sawOpen, clr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, refUp, refValid;
  logic [1:0] bresp, rresp, selRef, r;
  logic signed [PHASE_W-1:0] measPhase, phaseZero, snapPhase, phCap;
  logic signed [PHASE_W-1:0] psCap, spCap;
  logic signed [FREQ_W-1:0] measFreq, loopFreq, fodWord, freqCmd;
  logic signed [FREQ_W-1:0] freqReq, fodCap, frCap;
  logic [PSL_W-1:0] pslCode;
  dsfc_act_t act;
  int failures, checksDone, cyc;
  localparam logic [31:0] RSTV [6] = '{RST_CTRL, RST_PRIO, RST_PSL,
    RST_MAXF, RST_FLCFG, RST_FLLIM};

  dsfc_ctrl #(.MS_CYC(10)) uut (.clk, .resetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .refValid, .lockDetect, .phaseMeasDone, .measPhase, .freqMeasDone,
    .measFreq, .loopFreq, .selRef, .refActive, .holdover, .holdAlarm,
    .hsType, .phaseZero, .snapPhase, .fodWord, .freqCmd, .pslOn, .pslCode,
    .act);
  dsfc_ref_model #(.LOCK_DLY(6)) partner (.clk, .refUp, .freqReq,
    .refActive, .holdover, .holdAlarm, .refValid, .lockDetect,
    .phaseMeasDone, .measPhase, .freqMeasDone, .measFreq, .loopFreq);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task finish_test;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // one-cycle pulses are caught here so the sequence can check later
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (phaseMeasDone && holdover) phCap <= measPhase;
    if (phaseMeasDone && refActive) psCap <= measPhase;
    if (freqMeasDone) frCap <= measFreq;
    if (act.fodWrite === 1'h1) fodCap <= fodWord;
    if (act.phaseSnap === 1'h1) spCap <= snapPhase;
    if (!resetn || clr)
      {sawFod, sawWide, sawHit, sawAlarm, sawBw, sawOpen} <= '0;
    else begin
      sawFod <= sawFod | act.fodWrite;
      sawWide <= sawWide | act.wideAcq;
      sawHit <= sawHit | (holdover & ~holdAlarm);
      sawAlarm <= sawAlarm | holdAlarm;
      sawBw <= sawBw | act.bwMax;
      sawOpen <= sawOpen | act.openLoop;
    end
    if (cyc == 20000) begin
      failures = failures + 1;
      finish_test;
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // bready and rready stay high, which the bus allows
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
  endtask : rd

  initial begin
    {resetn, awvalid, wvalid, arvalid, clr, awaddr, araddr} = '0;
    {wdata, refUp, freqReq, failures, checksDone, cyc} = '0;
    {bready, rready} = 2'h3;
    wstrb = 4'hF;
    wt(8);
    resetn <= 1'h1;
    wt(1);
    rd(8'h20);
    `CHK("rresp unmapped", RESP_SLVERR, r)
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      `CHK("reset value", RSTV[i], d)
    end
    wr(ADDR_STATUS, 32'h0);
    `CHK("bresp status", RESP_SLVERR, r)
    wr(ADDR_FLCFG, 32'h0000_0099);
    `CHK("bresp flcfg", RESP_OKAY, r)
    refUp <= 4'h6;
    wt(30);
    `CHK("best ref", 2'h1, selRef)
    `CHK("freq snap", 1'h1, sawFod)
    `CHK("fod word", frCap, fodCap)
    `CHK("only top option", 1'h0, sawWide)
    refUp <= 4'h7;
    wt(20);
    `CHK("non-revert", 2'h1, selRef)
    wr(ADDR_CTRL, 32'h0000_00F1);
    wt(20);
    `CHK("revert", 2'h0, selRef)
    wr(ADDR_PRIO, 32'h0011_3210);
    refUp <= 4'h6;
    wt(20);
    refUp <= 4'h7;
    wt(20);
    `CHK("same group", 2'h1, selRef)
    wr(ADDR_CTRL, 32'h0000_00F3);
    clr <= 1'h1;
    wt(1);
    clr <= 1'h0;
    wr(ADDR_PRIO, RST_PRIO);
    wt(30);
    `CHK("hitless sel", 2'h0, selRef)
    `CHK("temp hold", 1'h1, sawHit)
    `CHK("no alarm", 1'h0, sawAlarm)
    `CHK("phase zero", phCap, phaseZero)
    `CHK("hitless type 1", 1'h0, hsType)
    wr(ADDR_CTRL, 32'h0000_00F7);
    refUp <= 4'h0;
    wt(5);
    `CHK("all lost", 1'h1, holdAlarm)
    clr <= 1'h1;
    wt(1);
    clr <= 1'h0;
    refUp <= 4'h4;
    wt(30);
    `CHK("leave hold", 1'h1, sawHit)
    `CHK("zero after hold", phCap, phaseZero)
    `CHK("hitless type 2", 1'h1, hsType)
    wr(ADDR_CTRL, 32'h0000_00B1);
    refUp <= 4'h6;
    wt(20);
    `CHK("ref disabled", 2'h1, selRef)
    wr(ADDR_MAXF, 32'h0000_0100);
    freqReq <= 24'sh001000;
    wt(4);
    `CHK("clamp high", 24'h000100, freqCmd)
    freqReq <= -24'sh001000;
    wt(4);
    `CHK("clamp low", 24'hFFFF00, freqCmd)
    wr(ADDR_PSL, 32'h0000_1D4B);
    wr(ADDR_CTRL, 32'h0000_00B9);
    wt(3);
    `CHK("slope on", 1'h1, pslOn)
    `CHK("slope code", 16'h1D4B, pslCode)
    // mid-run reset, then pre-acquire in acquire and snap in recovery
    refUp <= 4'h0;
    resetn <= 1'h0;
    wt(2);
    resetn <= 1'h1;
    wt(1);
    rd(ADDR_CTRL);
    `CHK("ctrl after reset", RST_CTRL, d)
    wr(ADDR_FLCFG, 32'h0002_168E);
    refUp <= 4'h4;
    wt(30);
    `CHK("pre-acquire", 1'h1, sawBw)
    `CHK("wide acquire", 1'h1, sawWide)
    `CHK("limits restored", 1'h0, pslOn)
    refUp <= 4'h2;
    wt(20);
    `CHK("phase snap", psCap, spCap)
    `CHK("no open loop", 1'h0, sawOpen)
    `CHK("recovered ref", 2'h1, selRef)
    finish_test;
  end
endmodule : dsfc_ctrl_bench
`undef CHK
`default_nettype wire
